// *** hw/tcap_pkg.sv ***
// Shared constants for the timer input-side capture and decode block
package tcap_pkg;
	// ==========================================================
	// Mode encodings
	localparam logic [1:0] MODE_CAPTURE = 2'h0;
	localparam logic [1:0] MODE_OUTPUT = 2'h1;
	localparam logic [1:0] MODE_COUNTER = 2'h2;
	localparam logic [1:0] MODE_QUAD_STEP = 2'h3;

	// ==========================================================
	// Counter limits and reset values
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// ==========================================================
	// Sequencer states, Gray along idle -> wait -> run
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_RUN = 2'h3
	} seq_t;
endpackage : tcap_pkg

// *** hw/pin_edge_sync.sv ***
// Three-stage pin synchroniser with agreement check and edge pulses
`timescale 1ns/10ps
module pin_edge_sync (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pin_in,
	output logic level,
	output logic rise,
	output logic fall
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;
	logic rise_ff;
	logic fall_ff;

	// ==========================================================
	// Synchroniser chain
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// ==========================================================
	// Level moves only when stages two and three agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			level_ff <= 1'b0;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else begin
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
			if (s2_ff == s3_ff && s3_ff != level_ff) begin
				level_ff <= s3_ff;
				rise_ff <= s3_ff;
				fall_ff <= ~s3_ff;
			end
		end
	end

	assign level = level_ff;
	assign rise = rise_ff;
	assign fall = fall_ff;
endmodule : pin_edge_sync

// *** hw/timer_input_capture_quadrature.sv ***
// Timer input modes: PWM capture, edge counter, quadrature and step decode
`timescale 1ns/10ps
module timer_input_capture_quadrature (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [1:0] mode_select,
	input wire logic edge_select,
	input wire logic output_polarity_sel,
	input wire logic timer_run,
	input wire logic base_tick,
	input wire logic rsd_source_sel,
	input wire logic zero_index_en,
	input wire logic pin_pulse_in,
	input wire logic pin_dir_in,
	input wire logic bemf_cmp_a,
	input wire logic bemf_cmp_b,
	input wire logic ext_irq1_input,
	input wire logic duty_wr_hi,
	input wire logic duty_wr_lo,
	input wire logic [7:0] duty_wdata,
	input wire logic count_rd_hi,
	input wire logic count_rd_lo,
	input wire logic pulse_flag_clr,
	input wire logic cycle_flag_clr,
	input wire logic overflow_flag_clr,
	output logic [7:0] count_rdata,
	output logic [15:0] duty_capture,
	output logic [15:0] period_capture,
	output logic pulse_flag,
	output logic cycle_flag,
	output logic overflow_flag,
	output logic direction_bit
);
	// ==========================================================
	// Reset release
	logic rst_a_ff;
	logic rst_n;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_a_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a_ff <= 1'b1;
			rst_n <= rst_a_ff;
		end
	end

	// ==========================================================
	// Pin synchronisers
	logic pul_lvl, pul_rise, pul_fall;
	logic dir_lvl;
	logic cma_lvl;
	logic cmb_lvl;
	logic zix_rise;

	pin_edge_sync u_pul (.clk_sys(clk_sys), .rst_n(rst_n), .pin_in(pin_pulse_in),
		.level(pul_lvl), .rise(pul_rise), .fall(pul_fall));
	pin_edge_sync u_dir (.clk_sys(clk_sys), .rst_n(rst_n), .pin_in(pin_dir_in),
		.level(dir_lvl), .rise(), .fall());
	pin_edge_sync u_cma (.clk_sys(clk_sys), .rst_n(rst_n), .pin_in(bemf_cmp_a),
		.level(cma_lvl), .rise(), .fall());
	pin_edge_sync u_cmb (.clk_sys(clk_sys), .rst_n(rst_n), .pin_in(bemf_cmp_b),
		.level(cmb_lvl), .rise(), .fall());
	pin_edge_sync u_zix (.clk_sys(clk_sys), .rst_n(rst_n), .pin_in(ext_irq1_input),
		.level(), .rise(zix_rise), .fall());

	// ==========================================================
	// Mode decode
	logic is_cap, is_cnt, is_quad, is_step;

	assign is_cap = (mode_select == tcap_pkg::MODE_CAPTURE);
	assign is_cnt = (mode_select == tcap_pkg::MODE_COUNTER);
	assign is_quad = (mode_select == tcap_pkg::MODE_QUAD_STEP) && !output_polarity_sel;
	assign is_step = (mode_select == tcap_pkg::MODE_QUAD_STEP) && output_polarity_sel;

	// ==========================================================
	// Edge roles
	logic start_edge, end_edge, act_edge;

	// Capture: period edge and pulse-end edge swap with edge select
	assign start_edge = edge_select ? pul_fall : pul_rise;
	assign end_edge = edge_select ? pul_rise : pul_fall;
	// Counter and step share the same active-edge choice
	assign act_edge = edge_select ? pul_rise : pul_fall;

	// ==========================================================
	// Quadrature decode
	// Channel A comes from the pulse pin or comparator A, B likewise.
	// A simultaneous change on both channels is illegal and is dropped.
	logic qa_lvl, qb_lvl, qa_chg, qb_chg;
	logic qa_old_ff, qb_old_ff;
	logic quad_edge, quad_rev;

	assign qa_lvl = rsd_source_sel ? cma_lvl : pul_lvl;
	assign qb_lvl = rsd_source_sel ? cmb_lvl : dir_lvl;
	assign qa_chg = qa_lvl != qa_old_ff;
	assign qb_chg = qb_lvl != qb_old_ff;
	assign quad_edge = qa_chg ^ qb_chg;
	assign quad_rev = ~(qa_lvl ^ qb_old_ff);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			qa_old_ff <= 1'b0;
			qb_old_ff <= 1'b0;
		end else begin
			qa_old_ff <= qa_lvl;
			qb_old_ff <= qb_lvl;
		end
	end

	// ==========================================================
	// Sequencer: idle while stopped, waiting for first edge, running
	tcap_pkg::seq_t seq_ff;
	tcap_pkg::seq_t nxt_seq;
	logic first_edge;

	assign first_edge = is_cap ? start_edge : act_edge;

	always_comb begin
		nxt_seq = seq_ff;
		case (seq_ff)
			tcap_pkg::ST_IDLE: begin
				if (timer_run) begin
					nxt_seq = tcap_pkg::ST_WAIT;
				end
			end
			tcap_pkg::ST_WAIT: begin
				if (first_edge) begin
					nxt_seq = tcap_pkg::ST_RUN;
				end
			end
			tcap_pkg::ST_RUN: begin
				nxt_seq = tcap_pkg::ST_RUN;
			end
			default: begin
				nxt_seq = tcap_pkg::ST_IDLE;
			end
		endcase
		if (!timer_run) begin
			nxt_seq = tcap_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seq_ff <= tcap_pkg::ST_IDLE;
		end else begin
			seq_ff <= nxt_seq;
		end
	end

	// ==========================================================
	// Event decode for base timer and flags
	logic waiting, running, base_ovf;
	logic cap_arm, cap_period, cap_pulse;
	logic cnt_step, cnt_match;
	logic sp_edge, sp_dn, zero_hit;
	logic [15:0] base_ff;
	logic [15:0] tally_ff;
	logic [15:0] target_ff;
	logic [15:0] tally_inc;

	assign waiting = (seq_ff == tcap_pkg::ST_WAIT) && timer_run;
	assign running = (seq_ff == tcap_pkg::ST_RUN) && timer_run;
	assign base_ovf = running && base_tick && (base_ff == tcap_pkg::CNT_MAX);
	assign cap_arm = is_cap && waiting && start_edge;
	assign cap_period = is_cap && running && start_edge;
	assign cap_pulse = is_cap && running && end_edge;
	assign tally_inc = tally_ff + tcap_pkg::CNT_ONE;
	assign cnt_step = is_cnt && running && act_edge;
	assign cnt_match = cnt_step && (tally_inc == target_ff);
	assign sp_edge = timer_run && (is_quad ? quad_edge : (is_step && act_edge));
	assign sp_dn = is_quad ? quad_rev : dir_lvl;
	assign zero_hit = is_quad && timer_run && zero_index_en && edge_select && zix_rise;

	// ==========================================================
	// Base timer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			base_ff <= tcap_pkg::CNT_RST;
		end else if (cap_arm || (is_cnt && waiting && act_edge)) begin
			base_ff <= tcap_pkg::CNT_RST;
		end else if (cap_period || cnt_match || (sp_edge && running)) begin
			base_ff <= tcap_pkg::CNT_RST;
		end else if (base_ovf) begin
			base_ff <= tcap_pkg::CNT_RST;
		end else if (running && base_tick) begin
			base_ff <= base_ff + tcap_pkg::CNT_ONE;
		end
	end

	// ==========================================================
	// Edge tally for counter mode, kept across base overflow
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tally_ff <= tcap_pkg::CNT_RST;
		end else if (!running || !is_cnt || cnt_match) begin
			tally_ff <= tcap_pkg::CNT_RST;
		end else if (cnt_step) begin
			tally_ff <= tally_inc;
		end
	end

	// ==========================================================
	// Target preload and shadow for counter mode
	logic [15:0] preload_ff;
	logic hi_pend_ff;
	logic xfer;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			preload_ff <= tcap_pkg::CNT_RST;
		end else if (duty_wr_hi && is_cnt) begin
			preload_ff[15:8] <= duty_wdata;
		end else if (duty_wr_lo && is_cnt) begin
			preload_ff[7:0] <= duty_wdata;
		end
	end

	// Pending from the high write until the low write lands
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hi_pend_ff <= 1'b0;
		end else if (duty_wr_hi && is_cnt) begin
			hi_pend_ff <= 1'b1;
		end else if (duty_wr_lo) begin
			hi_pend_ff <= 1'b0;
		end
	end

	assign xfer = (cnt_match || (is_cnt && base_ovf) || !timer_run)
		&& !hi_pend_ff && !duty_wr_hi && !duty_wr_lo;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			target_ff <= tcap_pkg::CNT_RST;
		end else if (xfer) begin
			target_ff <= preload_ff;
		end
	end

	// ==========================================================
	// Special up/down counter, wraps both ways
	logic [15:0] spec_ff;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			spec_ff <= tcap_pkg::CNT_RST;
		end else if (zero_hit) begin
			spec_ff <= tcap_pkg::CNT_RST;
		end else if (sp_edge && sp_dn) begin
			spec_ff <= spec_ff - tcap_pkg::CNT_ONE;
		end else if (sp_edge) begin
			spec_ff <= spec_ff + tcap_pkg::CNT_ONE;
		end
	end

	// ==========================================================
	// Direction; step mode waits for the pulse edge after a pin change
	logic dir_ff;
	logic dir_chg;

	assign dir_chg = sp_edge && (sp_dn != dir_ff);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dir_ff <= 1'b0;
		end else if (sp_edge) begin
			dir_ff <= sp_dn;
		end
	end

	// ==========================================================
	// Capture registers
	logic [15:0] duty_ff;
	logic [15:0] period_ff;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			duty_ff <= tcap_pkg::CNT_RST;
		end else if (cap_pulse) begin
			duty_ff <= base_ff;
		end else if (zero_hit) begin
			duty_ff <= spec_ff;
		end else if (is_cnt && duty_wr_hi) begin
			duty_ff[15:8] <= duty_wdata;
		end else if (is_cnt && duty_wr_lo) begin
			duty_ff[7:0] <= duty_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			period_ff <= tcap_pkg::CNT_RST;
		end else if (cap_period || cnt_match || (sp_edge && running)) begin
			period_ff <= base_ff;
		end
	end

	// ==========================================================
	// Flags; a set in the clearing cycle wins
	logic pulse_ff, cycle_ff, ovf_ff;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pulse_ff <= 1'b0;
		end else if (cap_pulse || dir_chg) begin
			pulse_ff <= 1'b1;
		end else if (pulse_flag_clr) begin
			pulse_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cycle_ff <= 1'b0;
		end else if (cap_period || cnt_match || (sp_edge && running)) begin
			cycle_ff <= 1'b1;
		end else if (cycle_flag_clr) begin
			cycle_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ovf_ff <= 1'b0;
		end else if (base_ovf) begin
			ovf_ff <= 1'b1;
		end else if (overflow_flag_clr) begin
			ovf_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Count read port; low byte frozen at the high-byte read
	logic [15:0] count_view;
	logic [7:0] lo_latch_ff;
	logic [7:0] rdata_ff;

	assign count_view = (is_quad || is_step) ? spec_ff : base_ff;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lo_latch_ff <= tcap_pkg::BYTE_RST;
			rdata_ff <= tcap_pkg::BYTE_RST;
		end else if (count_rd_hi) begin
			rdata_ff <= count_view[15:8];
			lo_latch_ff <= count_view[7:0];
		end else if (count_rd_lo) begin
			rdata_ff <= lo_latch_ff;
		end
	end

	assign count_rdata = rdata_ff;
	assign duty_capture = duty_ff;
	assign period_capture = period_ff;
	assign pulse_flag = pulse_ff;
	assign cycle_flag = cycle_ff;
	assign overflow_flag = ovf_ff;
	assign direction_bit = dir_ff;
endmodule : timer_input_capture_quadrature

// *** verif/tcap_chk.sv ***
// Port-level assertions for the timer input capture and decode block
`timescale 1ns/10ps
module tcap_chk (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [1:0] mode_select,
	input wire logic edge_select,
	input wire logic output_polarity_sel,
	input wire logic timer_run,
	input wire logic zero_index_en,
	input wire logic pin_pulse_in,
	input wire logic count_rd_hi,
	input wire logic count_rd_lo,
	input wire logic cycle_flag_clr,
	input wire logic [7:0] count_rdata,
	input wire logic [15:0] duty_capture,
	input wire logic [15:0] period_capture,
	input wire logic pulse_flag,
	input wire logic cycle_flag,
	input wire logic overflow_flag,
	input wire logic direction_bit
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// Cycles since the pulse pin last moved, saturating
	logic pin_prev_ff;
	logic [3:0] quiet_ff;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pin_prev_ff <= 1'b0;
			quiet_ff <= 4'hf;
		end else begin
			pin_prev_ff <= pin_pulse_in;
			if (pin_pulse_in != pin_prev_ff)
				quiet_ff <= 4'h0;
			else if (quiet_ff != 4'hf)
				quiet_ff <= quiet_ff + 4'h1;
		end
	end
	// ==========================================================
	// Assertions
	a_duty_on_pulse: assert property (mode_select == tcap_pkg::MODE_CAPTURE
		&& $stable(mode_select) && $changed(duty_capture) |-> pulse_flag)
		else $error("duty capture moved without pulse flag");
	a_period_on_cycle: assert property (mode_select != tcap_pkg::MODE_OUTPUT
		&& $stable(mode_select) && $changed(period_capture) |-> cycle_flag)
		else $error("period capture moved without cycle flag");
	a_dir_sets_flag: assert property (mode_select == tcap_pkg::MODE_QUAD_STEP
		&& $stable(mode_select) && $changed(direction_bit) |-> pulse_flag)
		else $error("direction change without flag");
	a_dir_on_pulse: assert property (mode_select == tcap_pkg::MODE_QUAD_STEP
		&& output_polarity_sel && $stable(output_polarity_sel) && $changed(direction_bit)
		|-> quiet_ff < 4'h8)
		else $error("step direction moved without a pulse edge");
	a_zero_cause: assert property (mode_select == tcap_pkg::MODE_QUAD_STEP
		&& $stable(mode_select) && $changed(duty_capture)
		|-> $past(zero_index_en) && $past(edge_select))
		else $error("zero index capture while disabled");
	a_rdata_holds: assert property (!count_rd_hi && !count_rd_lo |=> $stable(count_rdata))
		else $error("read byte changed without a read");
	a_ovf_needs_run: assert property ($rose(overflow_flag) |-> $past(timer_run))
		else $error("overflow while stopped");
	a_output_inert: assert property (mode_select == tcap_pkg::MODE_OUTPUT
		&& $stable(mode_select) && cycle_flag_clr |=> !cycle_flag)
		else $error("cycle flag set in output mode");
	c_ovf: cover property ($rose(overflow_flag));
	c_dir: cover property ($rose(direction_bit));
	c_read: cover property (count_rd_hi ##1 count_rd_lo);
endmodule : tcap_chk

bind timer_input_capture_quadrature tcap_chk i_chk (.clk_sys, .reset_n, .mode_select,
	.edge_select, .output_polarity_sel, .timer_run, .zero_index_en, .pin_pulse_in,
	.count_rd_hi, .count_rd_lo, .cycle_flag_clr, .count_rdata, .duty_capture,
	.period_capture, .pulse_flag, .cycle_flag, .overflow_flag, .direction_bit);

// *** verif/pulse_src.sv ***
// External pulse source: PWM, step and direction, quadrature and zero index
`timescale 1ns/10ps
module pulse_src (
	input wire logic clk_sys,
	output logic pulse_o,
	output logic dir_o,
	output logic cmp_a_o,
	output logic cmp_b_o,
	output logic zero_o
);
	logic [1:0] ph;
	initial begin
		pulse_o = 1'b0;
		dir_o = 1'b0;
		cmp_a_o = 1'b0;
		cmp_b_o = 1'b0;
		zero_o = 1'b0;
		ph = 2'h0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : hold
	task automatic pwm(input int hi, input int lo, input int n);
		@(posedge clk_sys);
		repeat (n) begin
			pulse_o <= 1'b1;
			hold(hi);
			pulse_o <= 1'b0;
			hold(lo);
		end
	endtask : pwm
	task automatic set_dir(input logic d);
		@(posedge clk_sys);
		dir_o <= d;
	endtask : set_dir
	// Quarter-spaced channels, one change every 6 cycles, never both at once
	task automatic quad(input logic fwd, input int n);
		@(posedge clk_sys);
		repeat (n) begin
			ph = fwd ? ph + 2'h1 : ph - 2'h1;
			cmp_a_o <= (ph == 2'h1) || (ph == 2'h2);
			cmp_b_o <= ph[1];
			hold(6);
		end
	endtask : quad
	task automatic zero;
		@(posedge clk_sys);
		zero_o <= 1'b1;
		hold(6);
		zero_o <= 1'b0;
		hold(6);
	endtask : zero
endmodule : pulse_src

// *** verif/timer_input_capture_quadrature_tb.sv ***
// Self-checking bench for the timer input capture and decode block
`timescale 1ns/10ps
module timer_input_capture_quadrature_tb;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [1:0] mode_select = 2'h0;
	logic edge_select = 1'b0, output_polarity_sel = 1'b0, timer_run = 1'b0;
	logic rsd_source_sel = 1'b0, zero_index_en = 1'b0, duty_wr_hi = 1'b0, duty_wr_lo = 1'b0;
	logic count_rd_hi = 1'b0, count_rd_lo = 1'b0, pulse_flag_clr = 1'b0;
	logic cycle_flag_clr = 1'b0, overflow_flag_clr = 1'b0, base_tick = 1'b1;
	logic [7:0] duty_wdata = 8'h00, count_rdata;
	logic pin_pulse_in, pin_dir_in, bemf_cmp_a, bemf_cmp_b, ext_irq1_input;
	logic [15:0] duty_capture, period_capture;
	logic pulse_flag, cycle_flag, overflow_flag, direction_bit;
	int err_count = 0;
	int comparisons = 0;
	typedef struct {logic es; int hi; int lo; logic [15:0] span;} cap_row_t;
	cap_row_t rows[3] = '{'{1'b0, 20, 30, 16'h001e}, '{1'b1, 20, 30, 16'h0014},
		'{1'b0, 5, 40, 16'h0028}};
	always #5 clk_sys = ~clk_sys;
	timer_input_capture_quadrature i_dut (.clk_sys, .reset_n, .mode_select, .edge_select,
		.output_polarity_sel, .timer_run, .base_tick, .rsd_source_sel, .zero_index_en,
		.pin_pulse_in, .pin_dir_in, .bemf_cmp_a, .bemf_cmp_b, .ext_irq1_input, .duty_wr_hi,
		.duty_wr_lo, .duty_wdata, .count_rd_hi, .count_rd_lo, .pulse_flag_clr, .cycle_flag_clr,
		.overflow_flag_clr, .count_rdata, .duty_capture, .period_capture, .pulse_flag,
		.cycle_flag, .overflow_flag, .direction_bit);
	pulse_src i_src (.clk_sys, .pulse_o(pin_pulse_in), .dir_o(pin_dir_in),
		.cmp_a_o(bemf_cmp_a), .cmp_b_o(bemf_cmp_b), .zero_o(ext_irq1_input));
	// ==========================================================
	// Helpers
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
		#1;
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk16
	task automatic chk1(input string name, input logic exp, input logic got);
		#1;
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask : chk1
	task automatic finish_test;
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	task automatic clr_flags;
		tick(1);
		pulse_flag_clr <= 1'b1;
		cycle_flag_clr <= 1'b1;
		overflow_flag_clr <= 1'b1;
		tick(1);
		pulse_flag_clr <= 1'b0;
		cycle_flag_clr <= 1'b0;
		overflow_flag_clr <= 1'b0;
	endtask : clr_flags
	task automatic rd_count(output logic [15:0] v);
		tick(1);
		count_rd_hi <= 1'b1;
		tick(1);
		count_rd_hi <= 1'b0;
		count_rd_lo <= 1'b1;
		#1 v[15:8] = count_rdata;
		tick(1);
		count_rd_lo <= 1'b0;
		#1 v[7:0] = count_rdata;
	endtask : rd_count
	// High byte strictly before low byte
	task automatic wr_duty(input logic [15:0] v);
		tick(1);
		duty_wdata <= v[15:8];
		duty_wr_hi <= 1'b1;
		tick(1);
		duty_wr_hi <= 1'b0;
		duty_wdata <= v[7:0];
		duty_wr_lo <= 1'b1;
		tick(1);
		duty_wr_lo <= 1'b0;
	endtask : wr_duty
	// ==========================================================
	// Main sequence
	initial begin
		logic [15:0] c0, c1, c2;
		int n;
		tick(20);
		reset_n <= 1'b1;
		tick(3);
		chk16("duty_capture", 16'h0000, duty_capture);
		chk16("period_capture", 16'h0000, period_capture);
		chk1("cycle_flag", 1'b0, cycle_flag);
		foreach (rows[i]) begin
			clr_flags();
			edge_select <= rows[i].es;
			timer_run <= 1'b1;
			i_src.pwm(rows[i].hi, rows[i].lo, 3);
			tick(8);
			chk16("capture span", rows[i].span, period_capture - duty_capture);
			chk1("pulse_flag", 1'b1, pulse_flag);
			chk1("cycle_flag", 1'b1, cycle_flag);
			tick(1);
			timer_run <= 1'b0;
		end
		// Base timer frozen while the prescaler tick is held off
		clr_flags();
		base_tick <= 1'b0;
		timer_run <= 1'b1;
		i_src.pwm(20, 30, 2);
		tick(8);
		chk16("period frozen", 16'h0000, period_capture);
		chk16("duty frozen", 16'h0000, duty_capture);
		tick(1);
		base_tick <= 1'b1;
		timer_run <= 1'b0;
		// Capture overflow with no closing edge
		clr_flags();
		edge_select <= 1'b0;
		timer_run <= 1'b1;
		i_src.pwm(5, 5, 1);
		for (n = 0; n < 70000 && overflow_flag !== 1'b1; n++)
			tick(1);
		chk1("overflow_flag", 1'b1, overflow_flag);
		chk1("cycle_flag", 1'b0, cycle_flag);
		if (overflow_flag !== 1'b1)
			finish_test();
		// Edge counter with a target of four
		tick(1);
		timer_run <= 1'b0;
		mode_select <= tcap_pkg::MODE_COUNTER;
		edge_select <= 1'b1;
		clr_flags();
		wr_duty(16'h0004);
		timer_run <= 1'b1;
		tick(1);
		timer_run <= 1'b0;
		tick(2);
		chk16("duty preload", 16'h0004, duty_capture);
		tick(1);
		timer_run <= 1'b1;
		i_src.pwm(4, 4, 4);
		tick(8);
		chk1("cycle_flag early", 1'b0, cycle_flag);
		i_src.pwm(4, 4, 1);
		tick(8);
		chk1("cycle_flag match", 1'b1, cycle_flag);
		// Half-written target must stay out of the shadow
		clr_flags();
		timer_run <= 1'b0;
		duty_wdata <= 8'h01;
		duty_wr_hi <= 1'b1;
		tick(1);
		duty_wr_hi <= 1'b0;
		tick(2);
		timer_run <= 1'b1;
		i_src.pwm(4, 4, 5);
		tick(8);
		chk1("cycle_flag blocked", 1'b1, cycle_flag);
		wr_duty(16'h0004);
		// Step and direction
		tick(1);
		timer_run <= 1'b0;
		mode_select <= tcap_pkg::MODE_QUAD_STEP;
		output_polarity_sel <= 1'b1;
		tick(1);
		timer_run <= 1'b1;
		clr_flags();
		rd_count(c0);
		i_src.pwm(4, 4, 3);
		tick(8);
		rd_count(c1);
		chk16("step count up", c0 + 16'h0003, c1);
		clr_flags();
		i_src.set_dir(1'b1);
		tick(10);
		chk1("direction_bit held", 1'b0, direction_bit);
		chk1("pulse_flag held", 1'b0, pulse_flag);
		i_src.pwm(4, 4, 5);
		tick(8);
		chk1("direction_bit", 1'b1, direction_bit);
		chk1("pulse_flag", 1'b1, pulse_flag);
		chk1("cycle_flag", 1'b1, cycle_flag);
		rd_count(c2);
		chk16("step count down", c1 - 16'h0005, c2);
		// Quadrature from comparators with zero index
		tick(1);
		output_polarity_sel <= 1'b0;
		rsd_source_sel <= 1'b1;
		zero_index_en <= 1'b1;
		i_src.zero();
		clr_flags();
		i_src.quad(1'b1, 16);
		tick(8);
		chk1("quad forward", 1'b0, direction_bit);
		rd_count(c1);
		chk16("quad count up", 16'h0010, c1);
		clr_flags();
		i_src.quad(1'b0, 8);
		tick(8);
		chk1("quad reverse", 1'b1, direction_bit);
		chk1("quad dir flag", 1'b1, pulse_flag);
		rd_count(c2);
		chk16("quad count down", c1 - 16'h0008, c2);
		i_src.zero();
		chk16("zero capture", c2, duty_capture);
		rd_count(c0);
		chk16("zero clear", 16'h0000, c0);
		// Output mode raises no cycle flag from the input logic
		tick(1);
		mode_select <= tcap_pkg::MODE_OUTPUT;
		tick(2);
		clr_flags();
		tick(2);
		chk1("output cycle_flag", 1'b0, cycle_flag);
		// Reset in mid-run clears captured state
		tick(1);
		reset_n <= 1'b0;
		tick(2);
		chk16("duty_capture reset", 16'h0000, duty_capture);
		chk16("period_capture reset", 16'h0000, period_capture);
		chk1("direction_bit reset", 1'b0, direction_bit);
		tick(1);
		reset_n <= 1'b1;
		tick(3);
		chk1("direction_bit after reset", 1'b0, direction_bit);
		chk1("overflow_flag after reset", 1'b0, overflow_flag);
		finish_test();
	end
endmodule : timer_input_capture_quadrature_tb
